// *** logic/ccis_fifo.v ***
// Small FIFO carrying host data line samples toward the card side
`timescale 1ns/1ns
module ccis_fifo #(
	parameter WIDTH = 3,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	// Clock and reset
	input  wire             i_sys_clk,
	input  wire             i_rstn,
	// Fill side
	input  wire             i_valid,
	output wire             o_ready,
	input  wire [WIDTH-1:0] i_data,
	// Drain side
	output wire             o_valid,
	input  wire             i_ready,
	output wire [WIDTH-1:0] o_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            push;
	wire            pop;

	assign o_ready = (count != DEPTH[AW:0]);
	assign o_valid = (count != {(AW+1){1'b0}});
	assign o_data  = mem[rd_ptr];
	assign push    = i_valid & o_ready;
	assign pop     = o_valid & i_ready;

	always @(posedge i_sys_clk) begin
		if (push)
			mem[wr_ptr] <= i_data;
	end

	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule

// *** logic/ccis_top.v ***
// Contact card interface sequencer: power-on, activation, clock, data lines, faults
`timescale 1ns/1ns
`include "ccis_defs.vh"
module ccis_top #(
	parameter LF_DIV = `CCIS_LF_DIV,
	parameter POR_LF = `CCIS_POR_LF,
	parameter DEB_LF = `CCIS_DEB_LF,
	parameter T_HF   = `CCIS_T_HF
) (
	// Clock and reset
	input  wire       i_sys_clk,
	input  wire       i_rstn,
	// Host controls
	input  wire       i_session_request_n,
	input  wire       i_host_reset_request,
	input  wire       i_card_clock_divide_sel,
	input  wire       i_chip_select,
	input  wire       i_ext_clock_in,
	// Supervisors and fault sensors
	input  wire       i_supply_ok,
	input  wire       i_overcurrent,
	input  wire       i_overheat,
	input  wire       i_card_present_n,
	// Host status, open drain
	output wire       o_fault_status_n,
	output wire       o_fault_status_oe,
	// Host data lines: data, aux a, aux b
	input  wire [2:0] i_host_lines,
	output wire [2:0] o_host_lines,
	output wire [2:0] o_host_lines_oe,
	// Card data lines: data, aux a, aux b
	input  wire [2:0] i_card_lines,
	output wire [2:0] o_card_lines,
	output wire [2:0] o_card_lines_oe,
	// Card contacts and oscillator mode
	output reg        o_card_supply_en,
	output reg        o_card_clock,
	output reg        o_card_reset,
	output wire       o_osc_high
);
	// ==========================================================
	// Input synchronisers
	reg [4:0] sync1;
	reg [4:0] sync2;
	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sync1 <= 5'h1f;
			sync2 <= 5'h1f;
		end else begin
			sync1 <= {i_session_request_n, i_card_present_n, i_supply_ok, i_ext_clock_in, i_chip_select};
			sync2 <= sync1;
		end
	end
	wire req_raw_n = sync2[4];
	wire pres_n    = sync2[3];
	wire sup_ok    = sync2[2];
	wire ext_clk   = sync2[1];
	wire cs        = sync2[0];

	// ==========================================================
	// Chip select latch
	reg req_n;
	reg rst_req;
	reg div_sel;
	// controls latched while chip select low
	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			req_n   <= 1'b1;
			rst_req <= 1'b0;
			div_sel <= 1'b0;
		end else if (cs) begin
			req_n   <= req_raw_n;
			rst_req <= i_host_reset_request;
			div_sel <= i_card_clock_divide_sel;
		end
	end

	// ==========================================================
	// Oscillator ticks
	reg  [7:0]  lf_cnt;
	reg         osc_high;
	wire        lf_tick = (lf_cnt == LF_DIV[7:0] - 8'h01);
	// High mode ticks every clock; low mode divides down
	wire        tick = osc_high | lf_tick;
	assign o_osc_high = osc_high;
	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn)
			lf_cnt <= 8'h00;
		else
			lf_cnt <= lf_tick ? 8'h00 : lf_cnt + 8'h01;
	end

	// ==========================================================
	// Presence debounce
	reg [10:0] deb_cnt;
	reg        present;
	wire       pres_raw = ~pres_n;
	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			deb_cnt <= 11'h000;
			present <= 1'b0;
		end else if (!pres_raw) begin
			present <= 1'b0;
			deb_cnt <= 11'h000;
		end else if (!present && lf_tick) begin
			if (deb_cnt == DEB_LF[10:0] - 11'h001)
				present <= 1'b1;
			else
				deb_cnt <= deb_cnt + 11'h001;
		end
	end

	// ==========================================================
	// Sequencer
	reg [2:0]  state;
	reg [11:0] seq_cnt;
	reg        fault_n;
	reg        fault_latched;
	reg        req_n_d;
	reg        io_en;
	reg        rst_en;
	reg        clk_en;
	reg [3:0]  clk_dly;
	wire       session_fault = i_overcurrent | i_overheat | ~present | ~sup_ok;
	wire       req_fall = req_n_d & ~req_n;
	wire [11:0] half_t = T_HF[12:1];
	// Backward points follow T so a short test T keeps the same proportions
	localparam [11:0] DEA_RST = (`CCIS_DEA_RST * T_HF) / `CCIS_DEA_DIV;
	localparam [11:0] DEA_CLK = (`CCIS_DEA_CLK * T_HF) / `CCIS_DEA_DIV;
	localparam [11:0] DEA_IO  = (`CCIS_DEA_IO * T_HF) / `CCIS_DEA_DIV;
	localparam [11:0] DEA_VCC = (`CCIS_DEA_VCC * T_HF) / `CCIS_DEA_DIV;

	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state            <= `CCIS_ST_POR;
			seq_cnt          <= 12'h000;
			osc_high         <= 1'b0;
			fault_n          <= 1'b0;
			fault_latched    <= 1'b0;
			req_n_d          <= 1'b1;
			io_en            <= 1'b0;
			rst_en           <= 1'b0;
			clk_en           <= 1'b0;
			o_card_supply_en <= 1'b0;
			clk_dly          <= 4'h0;
		end else begin
			req_n_d <= req_n;
			case (state)
			`CCIS_ST_POR: begin
				// hold inactive for the reset pulse
				if (!sup_ok)
					seq_cnt <= 12'h000;
				else if (lf_tick) begin
					if (seq_cnt == POR_LF[11:0] - 12'h001) begin
						seq_cnt <= 12'h000;
						state   <= `CCIS_ST_OFF;
					end else
						seq_cnt <= seq_cnt + 12'h001;
				end
			end
			`CCIS_ST_OFF: begin
				osc_high <= 1'b0;
				if (req_n) begin
					fault_n       <= present;
					fault_latched <= 1'b0;
				end
				if (!sup_ok)
					state <= `CCIS_ST_POR;
				else if (req_fall && !fault_latched) begin
					osc_high <= 1'b1;
					seq_cnt  <= 12'h000;
					state    <= `CCIS_ST_ACT;
				end
			end
			`CCIS_ST_ACT: begin
				// raised request is not taken during activation
				if (session_fault) begin
					fault_n       <= 1'b0;
					fault_latched <= 1'b1;
					seq_cnt       <= 12'h000;
					state         <= `CCIS_ST_DEACT;
				end else if (tick) begin
					seq_cnt <= seq_cnt + 12'h001;
					if (seq_cnt == half_t * `CCIS_ACT_VCC)
						o_card_supply_en <= 1'b1;
					if (seq_cnt == half_t * `CCIS_ACT_IO)
						io_en <= 1'b1;
					// card reset control enabled at 13T
					if (seq_cnt == half_t * `CCIS_ACT_RST) begin
						rst_en <= 1'b1;
						state  <= `CCIS_ST_ON;
					end
				end
				// clock enable 250 ns (5 system clocks) after data release
				if (io_en && !clk_en) begin
					if (clk_dly == `CCIS_CLK_START)
						clk_en <= 1'b1;
					else
						clk_dly <= clk_dly + 4'h1;
				end
			end
			`CCIS_ST_ON: begin
				if (session_fault || req_n) begin
					if (session_fault) begin
						fault_n       <= 1'b0;
						fault_latched <= 1'b1;
					end
					seq_cnt <= 12'h000;
					state   <= `CCIS_ST_DEACT;
				end
			end
			`CCIS_ST_DEACT: begin
				if (session_fault && fault_n) begin
					fault_n       <= 1'b0;
					fault_latched <= 1'b1;
				end
				if (tick) begin
					seq_cnt <= seq_cnt + 12'h001;
					if (seq_cnt == DEA_RST)
						rst_en <= 1'b0;
					if (seq_cnt == DEA_CLK)
						clk_en <= 1'b0;
					if (seq_cnt == DEA_IO)
						io_en <= 1'b0;
					if (seq_cnt == DEA_VCC) begin
						o_card_supply_en <= 1'b0;
						clk_dly          <= 4'h0;
						state            <= `CCIS_ST_OFF;
					end
				end
			end
			default: state <= `CCIS_ST_POR;
			endcase
		end
	end

	// ==========================================================
	// Card reset and clock
	reg ext_d;
	reg half;
	reg div_act;
	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_card_reset <= 1'b0;
			o_card_clock <= 1'b0;
			ext_d        <= 1'b0;
			half         <= 1'b0;
			div_act      <= 1'b0;
		end else begin
			o_card_reset <= rst_en & rst_req;
			ext_d        <= ext_clk;
			if (ext_clk && !ext_d) begin
				half <= ~half;
				// divide change taken only at a full low point
				if (!o_card_clock)
					div_act <= div_sel;
			end
			// full rate or toggle on each rising edge
			if (!clk_en)
				o_card_clock <= 1'b0;
			else if (!div_act)
				o_card_clock <= ext_clk;
			else if (ext_clk && !ext_d)
				o_card_clock <= ~o_card_clock;
		end
	end

	// ==========================================================
	// Data line pairs
	wire [2:0] host_in_q;
	wire       fifo_valid;
	wire       fifo_ready;
	// Host samples pass a FIFO; drain stalls while io_en is low (FIFO fills, h_now reads all high) but keeps order
	ccis_fifo #(
		.WIDTH (3),
		.DEPTH (4),
		.AW    (2)
	) u_fifo (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_valid   (1'b1),
		.o_ready   (fifo_ready),
		.i_data    (i_host_lines),
		.o_valid   (fifo_valid),
		.i_ready   (io_en),
		.o_data    (host_in_q)
	);

	reg [1:0] io_st   [0:2];
	reg [2:0] master_card;
	reg [1:0] io_cnt  [0:2];
	reg [2:0] h_prev;
	reg [2:0] c_prev;
	reg [2:0] drv_low;
	reg [2:0] drv_high;
	wire [2:0] h_now = (fifo_valid & fifo_ready) ? host_in_q : 3'h7;
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_line
			always @(posedge i_sys_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					io_st[g]       <= `CCIS_IO_IDLE;
					io_cnt[g]      <= 2'h0;
					master_card[g] <= 1'b0;
					h_prev[g]      <= 1'b1;
					c_prev[g]      <= 1'b1;
					drv_low[g]     <= 1'b0;
					drv_high[g]    <= 1'b0;
				end else begin
					h_prev[g] <= h_now[g];
					c_prev[g] <= i_card_lines[g];
					case (io_st[g])
					`CCIS_IO_IDLE: begin
						drv_high[g] <= 1'b0;
						if (io_en && cs) begin
							if (h_prev[g] && !h_now[g]) begin
								master_card[g] <= 1'b0;
								io_st[g]       <= `CCIS_IO_DELAY;
							end else if (c_prev[g] && !i_card_lines[g]) begin
								master_card[g] <= 1'b1;
								io_st[g]       <= `CCIS_IO_DELAY;
							end
							io_cnt[g] <= 2'h0;
						end
					end
					`CCIS_IO_DELAY: begin
						io_cnt[g] <= io_cnt[g] + 2'h1;
						if (io_cnt[g] == `CCIS_IO_EDGE_DLY - 1) begin
							drv_low[g] <= 1'b1;
							io_st[g]   <= `CCIS_IO_LOW;
						end
					end
					`CCIS_IO_LOW: begin
						if (master_card[g] ? i_card_lines[g] : h_now[g]) begin
							drv_low[g]  <= 1'b0;
							drv_high[g] <= 1'b1;
							io_cnt[g]   <= 2'h0;
							io_st[g]    <= `CCIS_IO_PULL;
						end
					end
					`CCIS_IO_PULL: begin
						io_cnt[g] <= io_cnt[g] + 2'h1;
						if (io_cnt[g] == `CCIS_IO_PU_DLY - 1) begin
							drv_high[g] <= 1'b0;
							io_st[g]    <= `CCIS_IO_IDLE;
						end
					end
					default: io_st[g] <= `CCIS_IO_IDLE;
					endcase
					if (!io_en || !cs) begin
						drv_low[g]  <= 1'b0;
						drv_high[g] <= 1'b0;
						io_st[g]    <= `CCIS_IO_IDLE;
					end
				end
			end
		end
	endgenerate

	// Slave side only is driven; card lines held low while not enabled
	wire [2:0] slave_drv = drv_low | drv_high;
	assign o_card_lines    = io_en ? drv_high : 3'h0;
	assign o_card_lines_oe = io_en ? (slave_drv & ~master_card) : 3'h7;
	assign o_host_lines    = drv_high;
	assign o_host_lines_oe = (cs & io_en) ? (slave_drv & master_card) : 3'h0;
	// status floats while deselected; open drain drives only low
	assign o_fault_status_n  = 1'b0;
	assign o_fault_status_oe = cs & ~fault_n;
endmodule

// *** pkg/ccis_defs.vh ***
// Timing counts and sequencer encodings for the card interface sequencer
`ifndef CCIS_DEFS_VH
`define CCIS_DEFS_VH

// Clock: 20 MHz system clock, 50 ns period
`define CCIS_CLK_NS        50
// Low-frequency oscillator tick, derived from the system clock
`define CCIS_LF_DIV        56
// High-frequency oscillator tick
`define CCIS_HF_DIV        1
// Power-on reset pulse in low-frequency periods
`define CCIS_POR_LF        2048
// Presence debounce in low-frequency periods
`define CCIS_DEB_LF        1280
// Sequencer unit T in high-frequency periods
`define CCIS_T_HF          64
// Activation points in units of T/2
`define CCIS_ACT_VCC       3
`define CCIS_ACT_IO        20
`define CCIS_ACT_RST       26
// Deactivation points in 64ths of T after the request rises, scaled by T
`define CCIS_DEA_DIV       64
`define CCIS_DEA_RST       3
`define CCIS_DEA_CLK       35
`define CCIS_DEA_IO        67
`define CCIS_DEA_VCC       99
// Card clock start delay after data release, in system clocks (200 ns min)
`define CCIS_CLK_START_NS  200
`define CCIS_CLK_START     ((`CCIS_CLK_START_NS + `CCIS_CLK_NS - 1) / `CCIS_CLK_NS)
// Sequencer states
`define CCIS_ST_POR        3'h0
`define CCIS_ST_OFF        3'h1
`define CCIS_ST_ACT        3'h2
`define CCIS_ST_ON         3'h3
`define CCIS_ST_DEACT      3'h4
// Data line pair states
`define CCIS_IO_IDLE       2'h0
`define CCIS_IO_DELAY      2'h1
`define CCIS_IO_LOW        2'h2
`define CCIS_IO_PULL       2'h3
// Data line delays in system clocks
`define CCIS_IO_EDGE_DLY   2
`define CCIS_IO_PU_DLY     2

`endif

// *** tb/ccis_asserts.sv ***
// Port checker for the card interface sequencer
`timescale 1ns/1ns
module ccis_asserts #(
	parameter LF_DIV = 56,
	parameter POR_LF = 2048,
	parameter DEB_LF = 1280,
	parameter T_HF   = 64
) (
	input wire       i_sys_clk,
	input wire       i_rstn,
	input wire       i_session_request_n,
	input wire       i_host_reset_request,
	input wire       i_card_clock_divide_sel,
	input wire       i_chip_select,
	input wire       i_ext_clock_in,
	input wire       i_supply_ok,
	input wire       i_overcurrent,
	input wire       i_overheat,
	input wire       i_card_present_n,
	input wire       o_fault_status_n,
	input wire       o_fault_status_oe,
	input wire [2:0] i_host_lines,
	input wire [2:0] o_host_lines,
	input wire [2:0] o_host_lines_oe,
	input wire [2:0] i_card_lines,
	input wire [2:0] o_card_lines,
	input wire [2:0] o_card_lines_oe,
	input wire       o_card_supply_en,
	input wire       o_card_clock,
	input wire       o_card_reset,
	input wire       o_osc_high
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	// ==========================================
	// Contact sequencing
	a_idle_contacts: assert property (!o_card_supply_en |-> !o_card_clock && !o_card_reset)
		else $error("card clock or reset active without supply");
	a_idle_lines_low: assert property (!o_card_supply_en |-> o_card_lines_oe == 3'h7 && o_card_lines == 3'h0)
		else $error("card lines not held low without supply");
	a_supply_osc: assert property (o_card_supply_en |-> o_osc_high)
		else $error("card supplied while oscillator slow");
	a_supply_wait: assert property ($rose(o_card_supply_en) |-> $past(o_osc_high, 8))
		else $error("supply rose too soon after oscillator switch");
	a_reset_late: assert property ($rose(o_card_reset) |-> $past(o_card_supply_en, 8))
		else $error("card reset enabled too early");
	// ==========================================
	// Host side and faults
	a_cs_float: assert property ((!i_chip_select) [*4] |-> !o_fault_status_oe && o_host_lines_oe == 3'h0)
		else $error("status or host lines driven with chip select low");
	a_removal_status: assert property ($rose(i_card_present_n) && o_card_supply_en && i_chip_select
		|-> ##[1:6] o_fault_status_oe)
		else $error("removal not flagged on status");
	a_fault_status: assert property ($rose(i_overcurrent || i_overheat) && o_card_supply_en && i_chip_select
		|-> ##[1:6] o_fault_status_oe)
		else $error("fault not flagged on status");
	a_data_follow: assert property ($fell(i_host_lines[0]) && o_card_supply_en && i_chip_select && i_card_lines[0]
		&& !o_card_lines_oe[0] && !o_host_lines_oe[0] |-> ##[2:8] (o_card_lines_oe[0] && !o_card_lines[0]))
		else $error("host low not passed to card line");
	c_activated: cover property ($rose(o_card_supply_en));
	c_fault: cover property ($rose(o_fault_status_oe) && o_card_supply_en);
	c_data: cover property ($rose(o_card_lines_oe[0]) && o_card_supply_en);
endmodule
bind ccis_top ccis_asserts #(.LF_DIV(LF_DIV), .POR_LF(POR_LF), .DEB_LF(DEB_LF), .T_HF(T_HF)) i_chk (.*);

// *** tb/ccis_card_model.sv ***
// Card side of the data lines: open drain with pull-up
`timescale 1ns/1ns
module ccis_card_model (
	// Device side of the lines
	input  wire [2:0] i_drive,
	input  wire [2:0] i_oe,
	// Card pulling a line low
	input  wire [2:0] i_card_low,
	// Resolved line levels
	output wire [2:0] o_lines
);
	assign o_lines = (i_oe & i_drive) | (~i_oe & ~i_card_low);
endmodule

// *** tb/test_contact_card_interface_sequencer.sv ***
// Self-checking bench for the card interface sequencer
`timescale 1ns/1ns
module test_contact_card_interface_sequencer;
	// ==========================================
	// Stimulus and observed wires
	reg        i_sys_clk = 0;
	reg        i_rstn = 0;
	reg        i_session_request_n = 1;
	reg        i_host_reset_request = 1;
	reg        i_card_clock_divide_sel = 0;
	reg        i_chip_select = 1;
	reg        i_ext_clock_in = 0;
	reg        i_supply_ok = 1;
	reg        i_overcurrent = 0;
	reg        i_overheat = 0;
	reg        i_card_present_n = 1;
	reg  [2:0] host_low = 0;
	reg  [2:0] card_low = 0;
	wire       o_fault_status_n;
	wire       o_fault_status_oe;
	wire [2:0] i_host_lines;
	wire [2:0] o_host_lines;
	wire [2:0] o_host_lines_oe;
	wire [2:0] i_card_lines;
	wire [2:0] o_card_lines;
	wire [2:0] o_card_lines_oe;
	wire       o_card_supply_en;
	wire       o_card_clock;
	wire       o_card_reset;
	wire       o_osc_high;
	wire [5:0] mon = {o_card_lines_oe[0], o_osc_high, o_fault_status_oe, o_card_reset, o_card_clock, o_card_supply_en};
	int        failures = 0;
	int        total_checks = 0;
	int        cycles = 0;
	// Host line pulled up unless someone drives it
	assign i_host_lines = (o_host_lines_oe & o_host_lines) | (~o_host_lines_oe & ~host_low);
	// Short counts keep the run brief
	ccis_top #(.LF_DIV(2), .POR_LF(4), .DEB_LF(4), .T_HF(8)) i_dut (.*);
	ccis_card_model i_card (.i_drive(o_card_lines), .i_oe(o_card_lines_oe), .i_card_low(card_low), .o_lines(i_card_lines));
	initial forever #25 i_sys_clk = ~i_sys_clk;
	// external clock runs from time zero
	initial forever #100 i_ext_clock_in = ~i_ext_clock_in;
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			tally_and_finish;
		end
	end
	// ==========================================
	// Shared helpers
	task tick(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	task wait_on(input int b, input logic v, output int n);
		n = 0;
		while (mon[b] !== v && n < 400) begin
			tick(1);
			n++;
		end
	endtask
	task chk(input string what, input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] got);
		total_checks++;
		if (^got === 1'bx || got < lo || got > hi) begin
			failures++;
			$display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ==========================================
	// Scenarios
	task t_por;
		int n;
		tick(40);
		chk("status_low", 1, 1, o_fault_status_oe);
		chk("status_value", 0, 0, o_fault_status_n);
		chk("supply", 0, 0, o_card_supply_en);
		chk("osc_high", 0, 0, o_osc_high);
		chk("host_oe", 0, 0, o_host_lines_oe);
		i_card_present_n = 0;
		tick(3);
		chk("status_low", 1, 1, o_fault_status_oe);
		wait_on(3, 0, n);
		chk("debounce", 2, 20, n);
		$display("test por done");
	endtask
	task t_activate;
		int a, b, c, d;
		i_session_request_n = 0;
		wait_on(0, 1, a);
		wait_on(5, 0, b);
		wait_on(1, 1, c);
		wait_on(2, 1, d);
		chk("supply_delay", 12, 20, a);
		chk("osc_high", 1, 1, o_osc_high);
		chk("release_delay", 67, 69, b);
		chk("clock_start", 4, 44, c);
		chk("reset_enable", 23, 25, c + d);
		$display("test activate done");
	endtask
	task t_data;
		int n, i;
		host_low[0] = 1;
		wait_on(5, 1, n);
		chk("card_follow", 2, 8, n);
		chk("card_line", 0, 0, i_card_lines[0]);
		host_low[0] = 0;
		n = 0;
		for (i = 0; i < 10; i++) begin
			tick(1);
			if (o_card_lines_oe[0] && o_card_lines[0])
				n++;
		end
		chk("pull_up", 2, 2, n);
		chk("card_oe", 0, 0, o_card_lines_oe[0]);
		card_low[1] = 1;
		tick(8);
		chk("host_follow", 0, 0, i_host_lines[1]);
		host_low[1] = 1;
		tick(10);
		chk("slave_ignored", 0, 0, o_card_lines_oe[1]);
		host_low[1] = 0;
		card_low[1] = 0;
		tick(10);
		$display("test data done");
	endtask
	task t_div;
		int s, i, n, h;
		logic p;
		for (s = 0; s < 2; s++) begin
			i_card_clock_divide_sel = s[0];
			tick(44);
			n = 0;
			h = 0;
			p = o_card_clock;
			for (i = 0; i < 80; i++) begin
				tick(1);
				if (o_card_clock === 1'b1 && p === 1'b0)
					n++;
				if (o_card_clock === 1'b1)
					h++;
				p = o_card_clock;
			end
			chk("clock_rises", s ? 9 : 19, s ? 11 : 21, n);
			chk("clock_high", 36, 44, h);
		end
		$display("test divide done");
	endtask
	task t_cs;
		i_chip_select = 0;
		tick(4);
		chk("status_oe", 0, 0, o_fault_status_oe);
		chk("host_oe", 0, 0, o_host_lines_oe);
		i_session_request_n = 1;
		host_low[0] = 1;
		tick(20);
		chk("latched", 1, 1, o_card_supply_en);
		chk("no_data", 0, 0, o_card_lines_oe);
		host_low = 0;
		$display("test chip select done");
	endtask
	task t_deact;
		int a, b, c, d;
		i_chip_select = 1;
		wait_on(2, 0, a);
		wait_on(5, 1, b);
		wait_on(0, 0, c);
		wait_on(4, 0, d);
		chk("reset_off", 0, 12, a);
		chk("lines_low", 7, 9, b);
		chk("supply_off", 3, 5, c);
		chk("osc_low", 0, 4, d);
		$display("test deactivate done");
	endtask
	task t_early;
		int n;
		tick(20);
		i_session_request_n = 0;
		tick(30);
		i_session_request_n = 1;
		wait_on(5, 0, n);
		chk("still_released", 40, 60, n);
		wait_on(0, 0, n);
		chk("then_off", 1, 150, n);
		tick(20);
		$display("test early release done");
	endtask
	task t_faults;
		int k, n;
		for (k = 0; k < 4; k++) begin
			t_activate;
			if (k == 0)
				i_overcurrent = 1;
			else if (k == 1)
				i_overheat = 1;
			else if (k == 2)
				i_card_present_n = 1;
			else
				i_supply_ok = 0;
			wait_on(3, 1, n);
			chk("fault_status", 1, 6, n);
			wait_on(0, 0, n);
			chk("emergency_off", 1, 120, n);
			i_overcurrent = 0;
			i_overheat = 0;
			i_supply_ok = 1;
			i_card_present_n = 0;
			i_session_request_n = 1;
			tick(60);
			chk("status_back", 0, 0, o_fault_status_oe);
			chk("osc_low", 0, 0, o_osc_high);
		end
		$display("test faults done");
	endtask
	initial begin
		tick(16);
		i_rstn = 1;
		t_por;
		t_activate;
		t_data;
		t_div;
		t_cs;
		t_deact;
		t_early;
		t_faults;
		tally_and_finish;
	end
endmodule
